// ===== common/dma_seq_pkg.sv
/*
  Constants, register map and state type for the DMA channel transfer
  sequencer. Assumes a byte-addressed register port with 32-bit data.
*/
`default_nettype none

package dma_seq_pkg;
  // ==========================================================
  // sizes
  localparam int CHANNELS_DEF = 4; // channels, at most 6
  localparam int ADDR_W_DEF = 24; // address and count width
  localparam int BUS_AW = 8; // register port address width
  localparam int BUS_DW = 32; // register port data width
  localparam int CTRL_W = 7; // stored control bits per channel

  // ==========================================================
  // register map: channel n at n*16, globals above
  localparam logic [3:0] OFF_CTRL = 4'h0; // channel control
  localparam logic [3:0] OFF_SRC = 4'h4; // source latch / working
  localparam logic [3:0] OFF_DST = 4'h8; // destination latch / working
  localparam logic [3:0] OFF_CNT = 4'hc; // count latch / remaining
  localparam logic [7:0] OFF_TCCTL = 8'h68; // terminate pin control
  localparam logic [7:0] OFF_STATUS = 8'h70; // end status, read clears
  localparam logic [7:0] OFF_MASK = 8'h74; // interrupt mask
  localparam int TC_VALID_BIT = 1; // terminate pin validity bit

  // ==========================================================
  // channel control fields
  localparam int CB_EN = 0; // channel enable
  localparam int CB_STYLE = 1; // 1 = cycle steal unless CB_LEVEL is set, 0 = burst
  localparam int CB_LEVEL = 2; // edge/level detection, 1 = level; here it only forces burst, requests stay edge set
  localparam int CB_RPT = 3; // 1 = repeat, 0 = single
  localparam int CB_WORD = 4; // 1 = 2-byte unit, 0 = 1-byte unit
  localparam int CB_SFIX = 5; // source address fixed
  localparam int CB_DFIX = 6; // destination address fixed
  localparam int CB_REQ = 8; // read only: request flag
  localparam int CB_ACT = 9; // read only: channel owns the bus

  // ==========================================================
  // reset values and timing
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00; // all channels off
  localparam int REQ_LAT_TENTHS = 15; // request to bus request, 0.1 phi
  localparam int REQ_LAT_CYC = (REQ_LAT_TENTHS + 9) / 10; // whole cycles

  typedef enum logic [3:0] {
    S_CPU = 4'h1, // cpu owns the bus
    S_ISSUE = 4'h2, // dma owns bus, loading one unit
    S_XFER = 4'h4, // unit on the bus
    S_EXT = 4'h8 // refresh or hold served without cpu
  } state_type;
endpackage

`default_nettype wire

// ===== rtl/dma_channel_transfer_sequencer.sv
/*
  DMA channel transfer sequencer: request flags, bus ownership, channel
  arbitration, single and repeat block modes, forced termination.
  Assumes a memory port that finishes each unit with XFER_DONE and a
  register master that follows the one-cycle strobe protocol.
*/
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module dma_channel_transfer_sequencer #(
  parameter int CHANNELS = dma_seq_pkg::CHANNELS_DEF, // channel count
  parameter int ADDR_W = dma_seq_pkg::ADDR_W_DEF // address width
)
(
  input wire logic MCLK, // system clock
  input wire logic RST, // async reset, high
  input wire logic [dma_seq_pkg::BUS_AW-1:0] ADDR, // register address
  input wire logic [dma_seq_pkg::BUS_DW-1:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  output logic [dma_seq_pkg::BUS_DW-1:0] RDATA, // read data, next cycle
  input wire logic [CHANNELS-1:0] DMA_REQ, // request sources
  input wire logic TERMINATE_COUNT_INPUT, // terminate pin
  input wire logic REFRESH_REQ, // memory refresh request
  input wire logic HOLD_REQ, // hold request
  input wire logic XFER_DONE, // unit finished on the bus
  output logic CPU_OWNS, // cpu owns the bus
  output logic INT_BLOCK, // interrupts held off
  output logic EXT_GRANT, // refresh or hold granted
  output logic BUS_REQUEST, // internal dma bus request
  output logic XFER_VALID, // unit on the bus
  output logic [$clog2(CHANNELS)-1:0] XFER_CH, // channel of the unit
  output logic [ADDR_W-1:0] XFER_SRC, // source address
  output logic [ADDR_W-1:0] XFER_DST, // destination address
  output logic XFER_WORD, // 2-byte unit
  output logic IRQ // level interrupt
);
  import dma_seq_pkg::*;
  localparam int CH_W = $clog2(CHANNELS);

  // ==========================================================
  // storage
  state_type state, next_state;
  logic [CH_W-1:0] act, next_act;
  logic resume;
  logic tc_valid, tc_prev;
  logic [CTRL_W-1:0] ctrl [CHANNELS];
  logic [ADDR_W-1:0] src_latch [CHANNELS];
  logic [ADDR_W-1:0] dst_latch [CHANNELS];
  logic [ADDR_W-1:0] cnt_latch [CHANNELS];
  logic [ADDR_W-1:0] src_work [CHANNELS];
  logic [ADDR_W-1:0] dst_work [CHANNELS];
  logic [ADDR_W-1:0] cnt_work [CHANNELS];
  logic [CHANNELS-1:0] req_flag, req_dly, req_prev, status, mask, en_vec;
  logic [BUS_DW-1:0] rd_val;

  // unit size in bytes
  function automatic logic [ADDR_W-1:0] unit_bytes(input logic [CTRL_W-1:0] c);
    unit_bytes = c[CB_WORD] ? ADDR_W'(2) : ADDR_W'(1);
  endfunction

  // next address, held when fixed
  function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] a,
                                             input logic fix,
                                             input logic [CTRL_W-1:0] c);
    step = fix ? a : a + unit_bytes(c);
  endfunction

  // lowest index wins
  function automatic logic [CH_W-1:0] first_req(input logic [CHANNELS-1:0] v);
    first_req = '0;
    for (int i = CHANNELS - 1; i >= 0; i--)
      if (v[i])
        first_req = CH_W'(i);
  endfunction

  // ==========================================================
  // register decode
  wire logic [3:0] reg_ch = ADDR[7:4];
  wire logic [3:0] reg_off = ADDR[3:0];
  wire logic ch_hit = reg_ch < 4'(CHANNELS);
  wire logic [CH_W-1:0] sel = reg_ch[CH_W-1:0];
  wire logic wr_ctrl = WR & ch_hit & (reg_off == OFF_CTRL);
  wire logic wr_src = WR & ch_hit & (reg_off == OFF_SRC);
  wire logic wr_dst = WR & ch_hit & (reg_off == OFF_DST);
  wire logic wr_cnt = WR & ch_hit & (reg_off == OFF_CNT);
  wire logic rd_status = RD & (ADDR == OFF_STATUS);

  for (genvar g = 0; g < CHANNELS; g++)
  begin : g_en
    assign en_vec[g] = ctrl[g][CB_EN];
  end

  // ==========================================================
  // active channel view
  wire logic [CTRL_W-1:0] cur = ctrl[act];
  wire logic steal = cur[CB_STYLE] & ~cur[CB_LEVEL];
  wire logic last = cnt_work[act] <= unit_bytes(cur);
  wire logic busy = state != S_CPU;
  wire logic done = (state == S_XFER) & XFER_DONE;
  wire logic ext = REFRESH_REQ | HOLD_REQ;
  wire logic [CHANNELS-1:0] act_hot = CHANNELS'(1) << act;

  // forced end: falling terminate edge hits the active channel, or all when idle
  wire logic tc_fall = tc_valid & tc_prev & ~TERMINATE_COUNT_INPUT;
  wire logic [CHANNELS-1:0] term = tc_fall ? (busy ? act_hot : '1) : '0;
  wire logic stop = ~cur[CB_EN] | (|(term & act_hot));
  wire logic batch_end = done & (last | stop);
  wire logic normal_end = batch_end & ~stop & ~cur[CB_RPT];
  wire logic reload = batch_end & ~stop & cur[CB_RPT];

  // ==========================================================
  // request flags: edge sets, set wins over clear
  wire logic [CHANNELS-1:0] rise = DMA_REQ & ~req_prev;
  wire logic [CHANNELS-1:0] burst_own = (busy & ~steal) ? act_hot : '0;
  wire logic [CHANNELS-1:0] unit_clr = (done & (steal | batch_end)) ? act_hot : '0;
  wire logic [CHANNELS-1:0] req_set = rise & en_vec & ~burst_own;
  wire logic [CHANNELS-1:0] req_clr = unit_clr | ~en_vec;
  wire logic [CHANNELS-1:0] next_flag = req_set | (req_flag & ~req_clr);
  // a flag counts as a bus request only once it has aged one cycle
  wire logic [CHANNELS-1:0] pend = req_flag & req_dly;
  wire logic [CHANNELS-1:0] pend_live = pend & ~req_clr;

  // flags, pin history
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      req_flag <= '0;
      req_dly <= '0;
      req_prev <= '0;
      tc_prev <= 1'b1;
    end
    else
    begin
      req_flag <= next_flag;
      req_dly <= req_flag & ~req_clr;
      req_prev <= DMA_REQ;
      tc_prev <= TERMINATE_COUNT_INPUT;
    end
  end

  // ==========================================================
  // ownership sequencing
  wire logic cont = (state == S_XFER) ? (~steal & ~batch_end) : resume;
  wire logic decide = done | ((state == S_EXT) & ~ext);

  always_comb
  begin
    next_state = state;
    next_act = act;
    case (state)
      S_CPU:
        if (|pend)
        begin
          next_state = S_ISSUE;
          next_act = first_req(pend);
        end
      S_ISSUE:
        next_state = S_XFER;
      S_XFER, S_EXT:
        if (decide)
        begin
          if (done & ext)
            next_state = S_EXT;
          else if (cont)
            next_state = S_ISSUE;
          else if (steal & (|pend_live))
          begin
            next_state = S_ISSUE;
            next_act = first_req(pend_live);
          end
          else
            next_state = S_CPU;
        end
      default:
        next_state = S_CPU;
    endcase
  end

  // state and bus-side outputs
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      state <= S_CPU;
      act <= '0;
      resume <= 1'b0;
      CPU_OWNS <= 1'b1;
      INT_BLOCK <= 1'b0;
      EXT_GRANT <= 1'b0;
      BUS_REQUEST <= 1'b0;
      XFER_VALID <= 1'b0;
    end
    else
    begin
      state <= next_state;
      act <= next_act;
      resume <= done ? cont : resume;
      CPU_OWNS <= next_state == S_CPU;
      INT_BLOCK <= next_state != S_CPU;
      EXT_GRANT <= next_state == S_EXT;
      BUS_REQUEST <= |pend;
      XFER_VALID <= next_state == S_XFER;
    end
  end

  // unit address and size, loaded as the unit is issued
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      XFER_CH <= '0;
      XFER_SRC <= '0;
      XFER_DST <= '0;
      XFER_WORD <= 1'b0;
    end
    else if (state == S_ISSUE)
    begin
      XFER_CH <= act;
      XFER_SRC <= src_work[act];
      XFER_DST <= dst_work[act];
      XFER_WORD <= cur[CB_WORD];
    end
  end

  // ==========================================================
  // channel registers: latches and working copies
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        ctrl[i] <= CTRL_RST;
        src_latch[i] <= '0;
        dst_latch[i] <= '0;
        cnt_latch[i] <= '0;
        src_work[i] <= '0;
        dst_work[i] <= '0;
        cnt_work[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        if (wr_ctrl & (sel == CH_W'(i)))
          ctrl[i] <= WDATA[CTRL_W-1:0];
        if (term[i] | (normal_end & (act == CH_W'(i))))
          ctrl[i][CB_EN] <= 1'b0;
        if (wr_src & (sel == CH_W'(i)))
          src_latch[i] <= WDATA[ADDR_W-1:0];
        if (wr_dst & (sel == CH_W'(i)))
          dst_latch[i] <= WDATA[ADDR_W-1:0];
        if (wr_cnt & (sel == CH_W'(i)))
          cnt_latch[i] <= WDATA[ADDR_W-1:0];
        if ((wr_ctrl & (sel == CH_W'(i)) & WDATA[CB_EN] & ~ctrl[i][CB_EN])
            | (reload & (act == CH_W'(i))))
        begin
          src_work[i] <= src_latch[i];
          dst_work[i] <= dst_latch[i];
          cnt_work[i] <= cnt_latch[i];
        end
        else if (done & (act == CH_W'(i)))
        begin
          src_work[i] <= step(src_work[i], ctrl[i][CB_SFIX], ctrl[i]);
          dst_work[i] <= step(dst_work[i], ctrl[i][CB_DFIX], ctrl[i]);
          cnt_work[i] <= last ? '0 : cnt_work[i] - unit_bytes(ctrl[i]);
        end
      end
    end
  end

  // ==========================================================
  // read mux: working registers read back, latches are write only
  always_comb
  begin
    rd_val = '0;
    if (ch_hit)
      case (reg_off)
        OFF_CTRL:
          rd_val = BUS_DW'({busy & (act == sel), req_flag[sel], 1'b0, ctrl[sel]});
        OFF_SRC:
          rd_val = BUS_DW'(src_work[sel]);
        OFF_DST:
          rd_val = BUS_DW'(dst_work[sel]);
        OFF_CNT:
          rd_val = BUS_DW'(cnt_work[sel]);
        default:
          rd_val = '0;
      endcase
    else if (ADDR == OFF_TCCTL)
      rd_val = BUS_DW'({tc_valid, 1'b0});
    else if (ADDR == OFF_STATUS)
      rd_val = BUS_DW'(status);
    else if (ADDR == OFF_MASK)
      rd_val = BUS_DW'(mask);
  end

  // status, mask, pin validity, read data, interrupt
  wire logic [CHANNELS-1:0] next_status = (normal_end ? act_hot : '0)
                                          | (status & ~(rd_status ? '1 : '0));

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      status <= '0;
      mask <= '0;
      tc_valid <= 1'b0;
      RDATA <= '0;
      IRQ <= 1'b0;
    end
    else
    begin
      status <= next_status;
      if (WR & (ADDR == OFF_MASK))
        mask <= WDATA[CHANNELS-1:0];
      if (WR & (ADDR == OFF_TCCTL))
        tc_valid <= WDATA[TC_VALID_BIT];
      RDATA <= RD ? rd_val : '0;
      IRQ <= |(next_status & mask);
    end
  end

  // ==========================================================
  // checks
  int_held_a: assert property (@(posedge MCLK) disable iff (RST)
    !CPU_OWNS |-> INT_BLOCK)
    else $error("interrupts open while dma owns bus");

  req_latency_a: assert property (@(posedge MCLK) disable iff (RST)
    (rise[0] && en_vec[0] && !req_flag[0]) |=> req_flag[0] && !pend[0])
    else $error("request reached bus request too early");

  burst_hold_a: assert property (@(posedge MCLK) disable iff (RST)
    (done && !steal && !ext && act == 0 && !batch_end) |=> req_flag[0] ##1 state == S_XFER)
    else $error("burst flag cleared mid batch");

  steal_clear_a: assert property (@(posedge MCLK) disable iff (RST)
    (done && steal && act == 0 && !rise[0]) |=> !req_flag[0])
    else $error("cycle steal flag not cleared");

  one_unit_a: assert property (@(posedge MCLK) disable iff (RST)
    (done && steal) |=> !XFER_VALID)
    else $error("second unit without new decision");

  ext_keep_a: assert property (@(posedge MCLK) disable iff (RST)
    (done && ext) |=> EXT_GRANT && !CPU_OWNS)
    else $error("refresh or hold not granted directly");

  cpu_return_a: assert property (@(posedge MCLK) disable iff (RST)
    (done && steal && !ext && pend_live == '0) |=> CPU_OWNS)
    else $error("bus kept with nothing pending");

  single_irq_a: assert property (@(posedge MCLK) disable iff (RST)
    (normal_end && act == 0) |=> status[0] && !en_vec[0])
    else $error("single end without interrupt");

  repeat_quiet_a: assert property (@(posedge MCLK) disable iff (RST)
    (done && cur[CB_RPT]) |=> $stable(status) || $past(rd_status))
    else $error("repeat mode raised interrupt");

  reload_a: assert property (@(posedge MCLK) disable iff (RST)
    (reload && act == 0) |=> cnt_work[0] == $past(cnt_latch[0]))
    else $error("repeat block did not reload");

  tc_stop_a: assert property (@(posedge MCLK) disable iff (RST)
    (tc_fall && busy && act == 0) |=> !en_vec[0])
    else $error("terminate edge ignored");
endmodule

`default_nettype wire

// ===== verification/bus_side_model.sv
/*
  Bus-side partner: answers each unit on the bus with one done pulse.
  Assumes the sequencer holds xfer_valid until the edge after done.
*/
`timescale 1ns/1ns
`default_nettype none

module bus_side_model
(
  input wire logic clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic xfer_valid, // unit on the bus
  input wire logic [3:0] delay, // cycles before done
  output logic xfer_done, // unit finished pulse
  output int units // units answered
);
  logic [3:0] wait_count;

  // ==========================================================
  // one done pulse per unit, after a set delay
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      xfer_done <= 1'h0;
      wait_count <= 4'h0;
      units <= 0;
    end
    else if (xfer_valid && !xfer_done)
    begin
      if (wait_count >= delay)
      begin
        xfer_done <= 1'h1;
        wait_count <= 4'h0;
        units <= units + 1;
      end
      else
        wait_count <= wait_count + 4'h1;
    end
    else
    begin
      xfer_done <= 1'h0;
      wait_count <= 4'h0;
    end
  end
endmodule

`default_nettype wire

// ===== verification/dma_channel_transfer_sequencer_tb.sv
/*
  Self-checking bench for the DMA channel transfer sequencer.
  Assumes the register map of dma_seq_pkg and four channels.
*/
`timescale 1ns/1ns
`default_nettype none

module dma_channel_transfer_sequencer_tb;
  import dma_seq_pkg::*;

  logic MCLK = 1'h0;
  logic RST = 1'h1;
  logic [BUS_AW-1:0] ADDR = '0;
  logic [BUS_DW-1:0] WDATA = '0;
  logic WR = 1'h0;
  logic RD = 1'h0;
  logic [BUS_DW-1:0] RDATA;
  logic [3:0] DMA_REQ = 4'h0;
  logic TERMINATE_COUNT_INPUT = 1'h1;
  logic REFRESH_REQ = 1'h0;
  logic HOLD_REQ = 1'h0;
  logic XFER_DONE, CPU_OWNS, INT_BLOCK, EXT_GRANT, BUS_REQUEST, XFER_VALID, XFER_WORD, IRQ;
  logic [1:0] XFER_CH;
  logic [23:0] XFER_SRC, XFER_DST;
  logic [3:0] delay = 4'h2;
  logic cpu_seen = 1'h0;
  int units, bad_count, n_tests, lat, u0;

  // ==========================================================
  // clock, design and partner
  always #20 MCLK = ~MCLK;

  dma_channel_transfer_sequencer #(.CHANNELS(4), .ADDR_W(24)) u_dut (
    .MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .DMA_REQ(DMA_REQ), .TERMINATE_COUNT_INPUT(TERMINATE_COUNT_INPUT),
    .REFRESH_REQ(REFRESH_REQ), .HOLD_REQ(HOLD_REQ), .XFER_DONE(XFER_DONE),
    .CPU_OWNS(CPU_OWNS), .INT_BLOCK(INT_BLOCK), .EXT_GRANT(EXT_GRANT),
    .BUS_REQUEST(BUS_REQUEST), .XFER_VALID(XFER_VALID), .XFER_CH(XFER_CH),
    .XFER_SRC(XFER_SRC), .XFER_DST(XFER_DST), .XFER_WORD(XFER_WORD), .IRQ(IRQ));

  bus_side_model u_bus (.clk(MCLK), .rst(RST), .xfer_valid(XFER_VALID),
    .delay(delay), .xfer_done(XFER_DONE), .units(units));

  // ==========================================================
  // compare, bus access and wait tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'h1;
    @(posedge MCLK);
    WR <= 1'h0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'h1;
    @(posedge MCLK);
    RD <= 1'h0;
    #1;
    chk(RDATA, exp, what);
  endtask

  task automatic cfg(input logic [7:0] b, input logic [31:0] s, d, c, ctl);
    wr(b + 8'(OFF_SRC), s);
    wr(b + 8'(OFF_DST), d);
    wr(b + 8'(OFF_CNT), c);
    wr(b, ctl);
  endtask

  task automatic req(input logic [3:0] m);
    @(posedge MCLK);
    DMA_REQ <= m;
    repeat (2) @(posedge MCLK);
    DMA_REQ <= 4'h0;
  endtask

  function automatic logic sel(input int s);
    case (s)
      0: return XFER_VALID;
      1: return CPU_OWNS;
      2: return EXT_GRANT;
      default: return XFER_VALID && XFER_CH == 2'h2;
    endcase
  endfunction

  task automatic wt(input int s, input logic v);
    int n;
    n = 0;
    #1;
    while (sel(s) !== v)
    begin
      @(posedge MCLK);
      #1;
      cpu_seen |= CPU_OWNS;
      n++;
      if (n > 300)
      begin
        bad_count++;
        $display("wrong value at %0t: wait %0d timed out", $time, s);
        wrap_up();
      end
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (8) @(posedge MCLK);
    RST <= 1'h0;
    @(posedge MCLK);
    #1;
    chk(32'({CPU_OWNS, INT_BLOCK, XFER_VALID, BUS_REQUEST, IRQ}), 32'h10, "reset");
    rdc(8'h7c, 32'h0, "unmapped");
    // cycle steal, two units on channel 0
    wr(OFF_MASK, 32'h1);
    cfg(8'h00, 32'h100, 32'h200, 32'h2, 32'h3);
    @(posedge MCLK);
    DMA_REQ <= 4'h1;
    lat = 0;
    while (BUS_REQUEST !== 1'h1 && lat < 20)
    begin
      @(posedge MCLK);
      #1;
      lat++;
    end
    chk(32'(lat), 32'h3, "latency");
    @(posedge MCLK);
    DMA_REQ <= 4'h0;
    wt(0, 1'h1);
    chk(32'({INT_BLOCK, CPU_OWNS, XFER_CH}), 32'h8, "owner");
    chk(32'({XFER_SRC, XFER_DST}), {8'h0, 24'h200}, "dst");
    chk(32'(XFER_SRC), 32'h100, "src");
    chk(32'(XFER_WORD), 32'h0, "byte unit");
    wt(1, 1'h1);
    rdc(8'h0c, 32'h1, "remaining");
    rdc(8'h04, 32'h101, "next src");
    rdc(8'h00, 32'h3, "flag");
    req(4'h1);
    wt(0, 1'h1);
    chk(32'(XFER_SRC), 32'h101, "second src");
    wt(1, 1'h1);
    repeat (2) @(posedge MCLK);
    #1;
    chk(32'(IRQ), 32'h1, "irq up");
    rdc(OFF_STATUS, 32'h1, "status");
    @(posedge MCLK);
    #1;
    chk(32'(IRQ), 32'h0, "irq clear");
    // two channels at once, bus kept between them
    cfg(8'h00, 32'h110, 32'h210, 32'h1, 32'h3);
    cfg(8'h20, 32'h120, 32'h220, 32'h1, 32'h3);
    req(4'h5);
    wt(0, 1'h1);
    chk(32'(XFER_CH), 32'h0, "first ch");
    cpu_seen = 1'h0;
    wt(3, 1'h1);
    chk(32'(cpu_seen), 32'h0, "bus kept");
    wt(1, 1'h1);
    rdc(OFF_STATUS, 32'h5, "status two");
    // edge burst with refresh and hold, repeat request ignored
    u0 = units;
    cfg(8'h10, 32'h300, 32'h400, 32'h4, 32'h11);
    req(4'h2);
    wt(0, 1'h1);
    chk(32'(XFER_WORD), 32'h1, "word unit");
    @(posedge MCLK);
    REFRESH_REQ <= 1'h1;
    HOLD_REQ <= 1'h1;
    wt(2, 1'h1);
    chk(32'(CPU_OWNS), 32'h0, "ext grant");
    @(posedge MCLK);
    REFRESH_REQ <= 1'h0;
    HOLD_REQ <= 1'h0;
    req(4'h2);
    wt(1, 1'h1);
    repeat (10) @(posedge MCLK);
    #1;
    chk(32'(units - u0), 32'h2, "batch");
    chk(32'({CPU_OWNS, IRQ}), 32'h2, "after batch");
    rdc(8'h10, 32'h10, "burst ctrl");
    rdc(8'h14, 32'h304, "burst src");
    rdc(OFF_STATUS, 32'h2, "masked end");
    // repeat mode, then terminate pin
    wr(OFF_MASK, 32'hf);
    cfg(8'h00, 32'h500, 32'h600, 32'h1, 32'hb);
    req(4'h1);
    wt(0, 1'h1);
    wt(1, 1'h1);
    repeat (3) @(posedge MCLK);
    #1;
    chk(32'(IRQ), 32'h0, "repeat irq");
    rdc(OFF_STATUS, 32'h0, "repeat status");
    rdc(8'h04, 32'h500, "reload src");
    rdc(8'h0c, 32'h1, "reload cnt");
    wr(OFF_TCCTL, 32'h2);
    @(posedge MCLK);
    TERMINATE_COUNT_INPUT <= 1'h0;
    rdc(8'h00, 32'ha, "forced end");
    u0 = units;
    req(4'h1);
    repeat (6) @(posedge MCLK);
    #1;
    chk(32'(units - u0), 32'h0, "no unit");
    wrap_up();
  end
endmodule

`default_nettype wire
